// ---- hw/ecm_pkg.sv ----
// package of constants and types for the engine driver mode controller
package ecm_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int POR_FILT_NS   = 500;
    localparam int POR_FILT_CYC  = (POR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam logic [9:0] SHORT_STEP_US = 10'h01e;
    localparam logic [9:0] OPEN_FILT_US  = 10'h080;

    // command word layout
    localparam int CMD_W      = 16;
    localparam int OPC_LSB    = 12;
    localparam int GD_ON_LSB  = 0;
    localparam int LR_SEL_LSB = 6;
    localparam int PIN_LSB    = 0;
    localparam int INT_LSB    = 6;
    localparam int PAR_LSB    = 0;
    localparam int PAIR_LSB   = 4;
    localparam int OL_BIT     = 8;
    localparam int DAC_LSB    = 0;
    localparam int CCD_ON_BIT = 8;
    localparam int CCD_PU_BIT = 9;
    localparam int SC_LSB     = 0;
    localparam int THR_LSB    = 5;

    // command codes
    localparam logic [3:0] OP_NOP    = 4'h0;
    localparam logic [3:0] OP_GD     = 4'h1;
    localparam logic [3:0] OP_PIN    = 4'h2;
    localparam logic [3:0] OP_ANDOR  = 4'h3;
    localparam logic [3:0] OP_LSS    = 4'h4;
    localparam logic [3:0] OP_LSSCFG = 4'h5;
    localparam logic [3:0] OP_CCD1   = 4'h6;
    localparam logic [3:0] OP_CCD2   = 4'h7;
    localparam logic [3:0] OP_SHORT  = 4'h8;
    localparam logic [3:0] OP_CAL    = 4'h9;
    localparam logic [3:0] OP_RST    = 4'ha;

    // reset values
    localparam logic [5:0] PIN_DIS_RST = 6'h00;
    localparam logic [5:0] INT_EN_RST  = 6'h00;
    localparam logic [5:0] ANDOR_RST   = 6'h00;
    localparam logic [3:0] PAR_EN_RST  = 4'hf;
    localparam logic [3:0] PAIR_RST    = 4'h0;
    localparam logic       OL_EN_RST   = 1'h1;
    localparam logic       CCD_PU_RST  = 1'h1;
    localparam logic [7:0] CCD_DAC_RST = 8'h00;

    typedef enum logic [1:0] {ECM_OFF, ECM_SLEEP, ECM_NORMAL, ECM_DEFAULT} ecm_mode_e;
endpackage

// ---- hw/ecm_if.sv ----
// interfaces between the mode controller and its helper modules
`timescale 1ns/100ps
interface ecm_sync_if;
    logic bat_raw;
    logic log_raw;
    logic en_raw;
    logic def_raw;
    logic bat_ok;
    logic log_ok;
    logic en_s;
    logic def_s;
    modport sync (input bat_raw, log_raw, en_raw, def_raw, output bat_ok, log_ok, en_s, def_s);
    modport ctrl (output bat_raw, log_raw, en_raw, def_raw, input bat_ok, log_ok, en_s, def_s);
endinterface

interface ecm_flt_if;
    logic       tick;
    logic       gate_on;
    logic       drain_hi;
    logic       drain_lo;
    logic [9:0] short_lim;
    logic       short_hit;
    logic       open_hit;
    modport filt (input tick, gate_on, drain_hi, drain_lo, short_lim, output short_hit, open_hit);
    modport ctrl (output tick, gate_on, drain_hi, drain_lo, short_lim, input short_hit, open_hit);
endinterface

// ---- hw/ecm_mode_sync.sv ----
// input synchroniser and supply glitch filter
`timescale 1ns/100ps
module ecm_mode_sync (
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    ecm_sync_if.sync  sif
);
    import ecm_pkg::*;

    typedef struct packed {
        logic [3:0]      s1;
        logic [3:0]      s2;
        logic [1:0][7:0] lo_cnt;
        logic [1:0]      ok;
    } ecm_sync_s;

    ecm_sync_s st_r;
    ecm_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = {sif.def_raw, sif.en_raw, sif.log_raw, sif.bat_raw};
        st_nxt.s2 = st_r.s1;
        // supply loss counts only once it lasts the filter time
        for (int i = 0; i < 2; i++) begin
            if (st_r.s2[i]) begin
                st_nxt.lo_cnt[i] = 8'h00;
                st_nxt.ok[i]     = 1'b1;
            end else if (st_r.lo_cnt[i] < 8'(POR_FILT_CYC - 1)) begin
                st_nxt.lo_cnt[i] = st_r.lo_cnt[i] + 8'h01;
            end else begin
                st_nxt.ok[i] = 1'b0;
            end
        end
        if (!resetn_i) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    assign sif.bat_ok = st_r.ok[0];
    assign sif.log_ok = st_r.ok[1];
    assign sif.en_s   = st_r.s2[2];
    assign sif.def_s  = st_r.s2[3];
endmodule

// ---- hw/ecm_drain_filter.sv ----
// per channel short and open fault filter on the drain sense
`timescale 1ns/100ps
module ecm_drain_filter (
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    ecm_flt_if.filt   flt
);
    import ecm_pkg::*;

    typedef struct packed {
        logic [9:0] s_cnt;
        logic [9:0] o_cnt;
        logic       s_hit;
        logic       o_hit;
    } ecm_flt_s;

    ecm_flt_s st_r;
    ecm_flt_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!(flt.gate_on && flt.drain_hi)) begin
            st_nxt.s_cnt = 10'h000;
        end else if (flt.tick && st_r.s_cnt < flt.short_lim) begin
            st_nxt.s_cnt = st_r.s_cnt + 10'h001;
        end
        if (!(!flt.gate_on && flt.drain_lo)) begin
            st_nxt.o_cnt = 10'h000;
        end else if (flt.tick && st_r.o_cnt < OPEN_FILT_US) begin
            st_nxt.o_cnt = st_r.o_cnt + 10'h001;
        end
        st_nxt.s_hit = st_r.s_cnt >= flt.short_lim;
        st_nxt.o_hit = st_r.o_cnt >= OPEN_FILT_US;
        if (!resetn_i) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    assign flt.short_hit = st_r.s_hit;
    assign flt.open_hit  = st_r.o_hit;
endmodule

// ---- hw/ecm_mode_ctrl.sv ----
// operating mode, reset and output gating controller of the engine driver
`timescale 1ns/100ps
module ecm_mode_ctrl #(
    parameter int N_GD  = 6,
    parameter int N_LSS = 8,
    parameter int DAC_W = 8
) (
    input  wire logic                    mclk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    battery_supply_i,
    input  wire logic                    logic_supply_i,
    input  wire logic                    enable_i,
    input  wire logic                    default_mode_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    cmd_ok_i,
    input  wire logic [ecm_pkg::CMD_W-1:0] cmd_word_i,
    input  wire logic [N_GD-1:0]         pwm_pin_i,
    input  wire logic [N_LSS/2-1:0]      parallel_switch_inputs_i,
    input  wire logic [N_GD-1:0]         internal_pwm_i,
    input  wire logic [N_GD-1:0]         drain_sense_short_i,
    input  wire logic [N_GD-1:0]         drain_sense_open_i,
    output ecm_pkg::ecm_mode_e           mode_o,
    output logic                         por_o,
    output logic [N_LSS-1:0]             low_side_switch_o,
    output logic                         open_load_current_o,
    output logic [1:0]                   constant_current_driver_o,
    output logic [1:0]                   ccd_pullup_o,
    output logic [2*DAC_W-1:0]           ccd_dac_o,
    output logic [N_GD-1:0]              gate_predriver_outputs_o,
    output logic [3:0]                   load_resistance_feedback_sel_o,
    output logic [3:0]                   short_threshold_o,
    output logic                         calibrate_o,
    output logic [N_GD-1:0]              fault_short_o,
    output logic [N_GD-1:0]              fault_open_o
);
    import ecm_pkg::*;

    if (N_GD != 6 || N_LSS != 8 || DAC_W < 1 || DAC_W > 8) begin : g_chk
        $error("unsupported channel counts or current code width");
    end

    typedef struct packed {
        ecm_mode_e            mode;
        logic                 por;
        logic                 cs_q;
        logic [7:0]           tick_cnt;
        logic                 tick;
        logic [N_GD-1:0]      gd_on;
        logic [3:0]           lr_sel;
        logic [N_GD-1:0]      pin_dis;
        logic [N_GD-1:0]      int_en;
        logic [N_GD-1:0]      andor;
        logic [N_LSS-1:0]     lss_on;
        logic [N_LSS/2-1:0]   par_en;
        logic [N_LSS/2-1:0]   pair;
        logic                 ol_en;
        logic [1:0]           ccd_on;
        logic [1:0]           ccd_pu;
        logic [2*DAC_W-1:0]   ccd_dac;
        logic [4:0]           short_code;
        logic [3:0]           short_thr;
        logic                 cal;
        logic [N_GD-1:0]      f_short;
        logic [N_GD-1:0]      f_open;
        logic [N_LSS-1:0]     lss_q;
        logic [N_GD-1:0]      gd_q;
        logic [1:0]           ccd_q;
    } ecm_st_s;

    ecm_st_s         st_r;
    ecm_st_s         st_nxt;
    ecm_sync_if      sif();
    logic [N_GD-1:0] hit_short;
    logic [N_GD-1:0] hit_open;
    logic [9:0]      short_lim;

    // gate channels taken off line by a load resistance measurement
    function automatic logic [5:0] lr_mask(input logic [3:0] sel);
        unique case (sel)
            4'h1, 4'h2, 4'ha: lr_mask = 6'h03;
            4'h3, 4'h4:       lr_mask = 6'h0c;
            4'h5, 4'h6:       lr_mask = 6'h30;
            4'hb:             lr_mask = 6'h05;
            4'hc:             lr_mask = 6'h09;
            4'hd:             lr_mask = 6'h11;
            4'he:             lr_mask = 6'h21;
            default:          lr_mask = 6'h00;
        endcase
    endfunction

    assign sif.bat_raw = battery_supply_i;
    assign sif.log_raw = logic_supply_i;
    assign sif.en_raw  = enable_i;
    assign sif.def_raw = default_mode_i;

    ecm_mode_sync u_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .sif      (sif.sync)
    );

    assign short_lim = ({5'h00, st_r.short_code} + 10'h001) * SHORT_STEP_US;

    for (genvar i = 0; i < N_GD; i++) begin : g_ch
        ecm_flt_if u_if();
        assign u_if.tick      = st_r.tick;
        assign u_if.gate_on   = st_r.gd_q[i];
        assign u_if.drain_hi  = drain_sense_short_i[i];
        assign u_if.drain_lo  = drain_sense_open_i[i];
        assign u_if.short_lim = short_lim;
        assign hit_short[i]   = u_if.short_hit;
        assign hit_open[i]    = u_if.open_hit;
        ecm_drain_filter u_flt (
            .mclk_i   (mclk_i),
            .resetn_i (resetn_i),
            .flt      (u_if.filt)
        );
    end

    always_comb begin
        ecm_mode_e           m;
        logic                take;
        logic                rst_cfg;
        logic                clr;
        logic [CMD_W-1:0]    w;
        logic [N_GD-1:0]     base;
        logic [5:0]          lmask;
        m       = ECM_OFF;
        take    = 1'b0;
        rst_cfg = 1'b0;
        clr     = 1'b0;
        w       = cmd_word_i;
        base    = '0;
        lmask   = lr_mask(st_r.lr_sel);
        st_nxt  = st_r;

        // mode decode from filtered supplies and synchronised pins
        if (!sif.bat_ok) begin
            m = ECM_OFF;
        end else if (!sif.log_ok || !sif.en_s) begin
            m = ECM_SLEEP;
        end else if (sif.def_s) begin
            m = ECM_DEFAULT;
        end else begin
            m = ECM_NORMAL;
        end
        st_nxt.mode = m;
        st_nxt.por  = (st_r.mode == ECM_OFF || st_r.mode == ECM_SLEEP) &&
                      (m == ECM_NORMAL || m == ECM_DEFAULT);
        // default to normal is not in the condition above, so no reset

        // one microsecond tick for the fault filters
        st_nxt.tick = 1'b0;
        if (st_r.tick_cnt == 8'(TICK_CYC - 1)) begin
            st_nxt.tick_cnt = 8'h00;
            st_nxt.tick     = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
        end

        // commands act on the rising chip select, in normal mode only
        st_nxt.cs_q = cs_n_i;
        take        = cs_n_i && !st_r.cs_q && cmd_ok_i && st_r.mode == ECM_NORMAL;
        clr         = !cs_n_i && st_r.cs_q && st_r.mode == ECM_NORMAL;
        st_nxt.cal  = 1'b0;
        if (take) begin
            unique case (w[OPC_LSB+:4])
                OP_GD: begin
                    st_nxt.gd_on  = w[GD_ON_LSB+:N_GD];
                    st_nxt.lr_sel = w[LR_SEL_LSB+:4];
                end
                OP_PIN: begin
                    st_nxt.pin_dis = w[PIN_LSB+:N_GD];
                    st_nxt.int_en  = w[INT_LSB+:N_GD];
                end
                OP_ANDOR:  st_nxt.andor = w[PIN_LSB+:N_GD];
                OP_LSS:    st_nxt.lss_on = w[0+:N_LSS];
                OP_LSSCFG: begin
                    st_nxt.par_en = w[PAR_LSB+:N_LSS/2];
                    st_nxt.pair   = w[PAIR_LSB+:N_LSS/2];
                    st_nxt.ol_en  = w[OL_BIT];
                end
                OP_CCD1: begin
                    st_nxt.ccd_on[0]          = w[CCD_ON_BIT];
                    st_nxt.ccd_pu[0]          = w[CCD_PU_BIT];
                    st_nxt.ccd_dac[0+:DAC_W]  = w[DAC_LSB+:DAC_W];
                end
                OP_CCD2: begin
                    st_nxt.ccd_on[1]             = w[CCD_ON_BIT];
                    st_nxt.ccd_pu[1]             = w[CCD_PU_BIT];
                    st_nxt.ccd_dac[DAC_W+:DAC_W] = w[DAC_LSB+:DAC_W];
                end
                OP_SHORT: begin
                    st_nxt.short_code = w[SC_LSB+:5];
                    st_nxt.short_thr  = w[THR_LSB+:4];
                end
                OP_CAL:  st_nxt.cal = 1'b1;
                OP_RST:  rst_cfg = 1'b1;
                OP_NOP:  ;
                default: ;
            endcase
        end

        // fault bits latch in normal mode only; a new fault beats the read clear
        if (st_r.mode == ECM_NORMAL) begin
            st_nxt.f_short = (st_r.f_short & ~{N_GD{clr}}) | hit_short;
            st_nxt.f_open  = (st_r.f_open & ~{N_GD{clr}}) | hit_open;
        end

        // gate drive source selection
        for (int i = 0; i < N_GD; i++) begin
            if (st_r.int_en[i]) begin
                base[i] = internal_pwm_i[i];
            end else if (st_r.pin_dis[i]) begin
                base[i] = st_r.gd_on[i];
            end else if (st_r.andor[i]) begin
                base[i] = st_r.gd_on[i] & pwm_pin_i[i];
            end else begin
                base[i] = st_r.gd_on[i] | pwm_pin_i[i];
            end
        end
        base = base & ~lmask;

        // outputs per mode
        st_nxt.lss_q = '0;
        st_nxt.gd_q  = '0;
        st_nxt.ccd_q = '0;
        if (st_r.mode == ECM_NORMAL) begin
            st_nxt.gd_q  = base;
            st_nxt.ccd_q = st_r.ccd_on;
            for (int k = 0; k < N_LSS / 2; k++) begin
                st_nxt.lss_q[2*k]   = st_r.lss_on[2*k] | (st_r.par_en[k] & parallel_switch_inputs_i[k]);
                st_nxt.lss_q[2*k+1] = st_r.lss_on[2*k+1] |
                                      (st_r.pair[k] & st_r.par_en[k] & parallel_switch_inputs_i[k]);
            end
        end else if (st_r.mode == ECM_DEFAULT) begin
            st_nxt.gd_q = pwm_pin_i;   // switches and current drivers stay off
        end
        if (st_r.por) begin
            st_nxt.gd_q = '0;
        end

        // registers held at reset values while off or asleep, and on any reset
        if (m == ECM_OFF || m == ECM_SLEEP || st_nxt.por || rst_cfg || !resetn_i) begin
            st_nxt.gd_on      = '0;
            st_nxt.lr_sel     = 4'h0;
            st_nxt.pin_dis    = PIN_DIS_RST;
            st_nxt.int_en     = INT_EN_RST;
            st_nxt.andor      = ANDOR_RST;
            st_nxt.lss_on     = '0;
            st_nxt.par_en     = PAR_EN_RST;
            st_nxt.pair       = PAIR_RST;
            st_nxt.ol_en      = OL_EN_RST;
            st_nxt.ccd_on     = 2'h0;
            st_nxt.ccd_pu     = {2{CCD_PU_RST}};
            st_nxt.ccd_dac    = {2{CCD_DAC_RST[DAC_W-1:0]}};
            st_nxt.short_code = 5'h00;
            st_nxt.short_thr  = 4'h0;
            st_nxt.f_short    = '0;
            st_nxt.f_open     = '0;
        end
        if (m == ECM_OFF || m == ECM_SLEEP) begin
            st_nxt.lss_q = '0;
            st_nxt.gd_q  = '0;
            st_nxt.ccd_q = '0;
        end
        // a short supply dip changes nothing above until the filter expires
        if (!resetn_i) begin
            st_nxt.mode     = ECM_OFF;
            st_nxt.por      = 1'b0;
            st_nxt.cs_q     = 1'b1;
            st_nxt.tick_cnt = 8'h00;
            st_nxt.tick     = 1'b0;
            st_nxt.cal      = 1'b0;
            st_nxt.lss_q    = '0;
            st_nxt.gd_q     = '0;
            st_nxt.ccd_q    = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    assign mode_o                         = st_r.mode;
    assign por_o                          = st_r.por;
    assign low_side_switch_o              = st_r.lss_q;
    assign open_load_current_o            = st_r.ol_en;
    assign constant_current_driver_o      = st_r.ccd_q;
    assign ccd_pullup_o                   = st_r.ccd_pu;
    assign ccd_dac_o                      = st_r.ccd_dac;
    assign gate_predriver_outputs_o       = st_r.gd_q;
    assign load_resistance_feedback_sel_o = st_r.lr_sel;
    assign short_threshold_o              = st_r.short_thr;
    assign calibrate_o                    = st_r.cal;
    assign fault_short_o                  = st_r.f_short;
    assign fault_open_o                   = st_r.f_open;

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    a_default_lss_off: assert property (st_r.mode == ECM_DEFAULT |=> low_side_switch_o == '0)
        else $error("switch active in default mode");
    a_default_ccd_off: assert property (st_r.mode == ECM_DEFAULT |=> constant_current_driver_o == 2'h0)
        else $error("current driver active in default mode");
    a_default_gd_pins: assert property (st_r.mode == ECM_DEFAULT && !st_r.por ##1 st_r.mode != ECM_OFF && st_r.mode != ECM_SLEEP
                                        |-> gate_predriver_outputs_o == $past(pwm_pin_i))
        else $error("gate output not following pin in default mode");
    a_default_cfg_hold: assert property (st_r.mode == ECM_DEFAULT ##1 st_r.mode != ECM_OFF && st_r.mode != ECM_SLEEP
                                         |-> $stable(st_r.lss_on) && $stable(st_r.f_short))
        else $error("state changed in default mode");
    a_exit_default_nopor: assert property (st_r.mode == ECM_DEFAULT ##1 st_r.mode == ECM_NORMAL |-> !por_o)
        else $error("reset on leaving default mode");
    a_wake_por_pulse: assert property (st_r.mode == ECM_SLEEP ##1 st_r.mode == ECM_NORMAL
                                       |-> por_o && st_r.lss_on == '0 && open_load_current_o)
        else $error("no reset on wake from sleep");
    a_por_gate_off: assert property (por_o |=> gate_predriver_outputs_o == '0)
        else $error("gate driven during reset");
    a_sleep_outs_off: assert property (st_r.mode == ECM_SLEEP
                                       |-> low_side_switch_o == '0 && gate_predriver_outputs_o == '0)
        else $error("output on in sleep");
    a_cmd_on_cs: assert property ($past(st_r.mode) == ECM_NORMAL && st_r.mode == ECM_NORMAL && $changed(st_r.lss_on)
                                  |-> $past(cs_n_i) && !$past(st_r.cs_q) && $past(cmd_ok_i))
        else $error("command applied without chip select rise");

    c_default_entry: cover property (st_r.mode == ECM_NORMAL ##1 st_r.mode == ECM_DEFAULT);
    c_sleep_wake:    cover property (st_r.mode == ECM_SLEEP ##1 st_r.mode == ECM_NORMAL);
    c_cmd_switch:    cover property (st_r.mode == ECM_NORMAL ##1 low_side_switch_o != '0);
    c_short_fault:   cover property (fault_short_o != '0);
endmodule

// ---- dv/ecm_host.sv ----
// host controller model framing command words on the chip select
`timescale 1ns/100ps
module ecm_host (
    input  wire logic        mclk_i,
    output logic             cs_n_o,
    output logic             cmd_ok_o,
    output logic [15:0]      cmd_word_o
);
    initial begin
        cs_n_o = 1'b1;
        cmd_ok_o = 1'b0;
        cmd_word_o = 16'hffff;
    end
    // word held through the cs rise cycle, scrambled once deselected
    task automatic send(input logic [15:0] w, input logic ok, input int gap);
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        cmd_word_o <= w;
        repeat (gap) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        cmd_ok_o <= ok;
        @(posedge mclk_i);
        cmd_word_o <= ~w;
        cmd_ok_o <= 1'b0;
    endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the engine driver mode controller
`timescale 1ns/100ps
module tb;
    import ecm_pkg::*;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        lgc = 1'b1;
    logic        en = 1'b1;
    logic        dflt = 1'b0;
    logic [5:0]  pwm = 6'h00;
    logic [3:0]  par = 4'h0;
    logic        cs_n, ok, olc, cal;
    logic [15:0] word, dac;
    ecm_mode_e   mode;
    logic [7:0]  lss;
    logic [1:0]  ccd, pu;
    logic [5:0]  gd;
    logic [5:0]  ipwm = 6'h3f;
    logic [5:0]  dsh = 6'h00;
    logic [5:0]  dop = 6'h00;
    logic [5:0]  fsh, fop;
    logic [3:0]  lrs, thr;
    logic        por;
    int          n_mismatch = 0;
    int          checked = 0;
    ecm_host ecm_host_inst (.mclk_i(mclk_i), .cs_n_o(cs_n), .cmd_ok_o(ok), .cmd_word_o(word));
    ecm_mode_ctrl ecm_mode_ctrl_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .battery_supply_i(1'b1),
        .logic_supply_i(lgc), .enable_i(en), .default_mode_i(dflt), .cs_n_i(cs_n), .cmd_ok_i(ok),
        .cmd_word_i(word), .pwm_pin_i(pwm), .parallel_switch_inputs_i(par), .internal_pwm_i(ipwm),
        .drain_sense_short_i(dsh), .drain_sense_open_i(dop), .mode_o(mode), .por_o(por),
        .low_side_switch_o(lss), .open_load_current_o(olc), .constant_current_driver_o(ccd),
        .ccd_pullup_o(pu), .ccd_dac_o(dac), .gate_predriver_outputs_o(gd),
        .load_resistance_feedback_sel_o(lrs), .short_threshold_o(thr), .calibrate_o(cal),
        .fault_short_o(fsh), .fault_open_o(fop));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic close_out();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task automatic wait_mode(input ecm_mode_e m);
        for (int i = 0; i < 400 && mode !== m; i++) @(negedge mclk_i);
        chk("mode", 16'(m), 16'(mode));
        if (mode !== m) close_out();
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        wait_mode(ECM_NORMAL);
        chk("por_up", 16'h0001, 16'(por));
        chk("lss_rst", 16'h0000, 16'(lss));
        chk("olc_rst", 16'h0001, 16'(olc));
        chk("pu_rst", 16'h0003, 16'(pu));
        chk("dac_rst", 16'h0000, dac);
        @(posedge mclk_i);
        par <= 4'h2;
        cyc(3);
        chk("lss_par", 16'h0004, 16'(lss));
        ecm_host_inst.send(16'h512f, 1'b1, 1);
        cyc(3);
        chk("lss_pair", 16'h000c, 16'(lss));
        @(posedge mclk_i);
        par <= 4'h0;
        ecm_host_inst.send(16'h40ff, 1'b0, 1);
        cyc(3);
        chk("lss_bad", 16'h0000, 16'(lss));
        ecm_host_inst.send(16'h4081, 1'b1, 4);
        ecm_host_inst.send(16'h615a, 1'b1, 1);
        pwm <= 6'h21;
        ecm_host_inst.send(16'h1003, 1'b1, 2);
        cyc(3);
        chk("lss_cmd", 16'h0081, 16'(lss));
        chk("ccd_cmd", 16'h0001, 16'(ccd));
        chk("gd_or", 16'h0023, 16'(gd));
        ecm_host_inst.send(16'h3002, 1'b1, 1);
        cyc(3);
        chk("gd_and", 16'h0021, 16'(gd));
        ecm_host_inst.send(16'h1043, 1'b1, 1);
        cyc(3);
        chk("gd_lr", 16'h0020, 16'(gd));
        chk("lr_sel", 16'h0001, 16'(lrs));
        ecm_host_inst.send(16'h80a0, 1'b1, 1);
        dsh <= 6'h20;
        dop <= 6'h04;
        for (int i = 0; i < 27000 && fop === 6'h00; i++) @(negedge mclk_i);
        chk("thr", 16'h0005, 16'(thr));
        chk("f_short", 16'h0020, 16'(fsh));
        chk("f_open", 16'h0004, 16'(fop));
        if (fop === 6'h00) close_out();
        @(posedge mclk_i);
        dsh <= 6'h00;
        dop <= 6'h00;
        cyc(3);
        chk("f_hold", 16'h0020, 16'(fsh));
        ecm_host_inst.send(16'h0000, 1'b1, 1);
        cyc(2);
        chk("f_clr_s", 16'h0000, 16'(fsh));
        chk("f_clr_o", 16'h0000, 16'(fop));
        ecm_host_inst.send(16'h2fc0, 1'b1, 1);
        ipwm <= 6'h14;
        cyc(3);
        chk("gd_int", 16'h0014, 16'(gd));
        @(posedge mclk_i);
        dflt <= 1'b1;
        wait_mode(ECM_DEFAULT);
        ecm_host_inst.send(16'h4000, 1'b1, 1);
        cyc(3);
        chk("lss_dflt", 16'h0000, 16'(lss));
        chk("ccd_dflt", 16'h0000, 16'(ccd));
        chk("gd_dflt", 16'h0021, 16'(gd));
        @(posedge mclk_i);
        dflt <= 1'b0;
        wait_mode(ECM_NORMAL);
        chk("por_dflt", 16'h0000, 16'(por));
        cyc(2);
        chk("lss_back", 16'h0081, 16'(lss));
        chk("dac_back", 16'h005a, dac);
        @(posedge mclk_i);
        lgc <= 1'b0;
        repeat (50) @(posedge mclk_i);
        lgc <= 1'b1;
        cyc(200);
        chk("mode_dip", 16'(ECM_NORMAL), 16'(mode));
        chk("lss_dip", 16'h0081, 16'(lss));
        ecm_host_inst.send(16'h9000, 1'b1, 1);
        for (int i = 0; i < 8 && cal !== 1'b1; i++) @(negedge mclk_i);
        chk("cal", 16'h0001, 16'(cal));
        ecm_host_inst.send(16'h0000, 1'b1, 1);
        cyc(3);
        chk("lss_nop", 16'h0081, 16'(lss));
        @(posedge mclk_i);
        pwm <= 6'h00;
        en <= 1'b0;
        wait_mode(ECM_SLEEP);
        cyc(2);
        chk("lss_slp", 16'h0000, 16'(lss));
        chk("ccd_slp", 16'h0000, 16'(ccd));
        @(posedge mclk_i);
        en <= 1'b1;
        wait_mode(ECM_NORMAL);
        chk("por_wake", 16'h0001, 16'(por));
        cyc(2);
        chk("dac_por", 16'h0000, dac);
        chk("pu_por", 16'h0003, 16'(pu));
        chk("gd_por", 16'h0000, 16'(gd));
        ecm_host_inst.send(16'h4003, 1'b1, 1);
        cyc(3);
        chk("lss_set", 16'h0003, 16'(lss));
        ecm_host_inst.send(16'ha000, 1'b1, 1);
        cyc(3);
        chk("lss_srst", 16'h0000, 16'(lss));
        close_out();
    end
endmodule
